/* File: verilog/supply_pkg.sv */
// shared constants and types of the panel supply serial register block
// assumes a 125 MHz system clock and an external serial bus master
`default_nettype none
package supply_pkg;
    // system clock and store cycle timing
    localparam int clk_khz = 125000;
    localparam int store_time_ms = 25;
    localparam int store_cycles = store_time_ms * clk_khz;

    // slave address upper bits, low bit comes from the select pin
    localparam logic [5:0] dev_addr_hi = 6'h10;

    // register pointer space
    localparam int num_levels = 10;
    localparam logic [7:0] ptr_last = 8'h09;
    localparam logic [7:0] ptr_ctrl = 8'hff;

    // register indices inside the level bank
    localparam logic [3:0] idx_boost_rail = 4'h0;
    localparam logic [3:0] idx_half_rail = 4'h1;
    localparam logic [3:0] idx_io_rail = 4'h2;
    localparam logic [3:0] idx_core_rail = 4'h3;
    localparam logic [3:0] idx_gate_on_cold = 4'h4;
    localparam logic [3:0] idx_gate_on_hot = 4'h5;
    localparam logic [3:0] idx_gate_off = 4'h6;
    localparam logic [3:0] idx_seq_delay_first = 4'h7;
    localparam logic [3:0] idx_seq_delay_second = 4'h8;
    localparam logic [3:0] idx_seq_delay_third = 4'h9;

    // control register codes
    localparam logic [7:0] ctrl_read_vol = 8'h00;
    localparam logic [7:0] ctrl_read_nv = 8'h01;
    localparam logic [7:0] ctrl_store = 8'h80;
    localparam logic [7:0] ctrl_reset = 8'h00;

    // bit counter positions within a nine-clock byte slot
    localparam logic [3:0] bit_last = 4'h7;
    localparam logic [3:0] bit_ack = 4'h8;

    typedef logic [num_levels-1:0][7:0] level_bank_t;

    // power-up contents, index 9 down to 0
    localparam level_bank_t level_reset = {8'h03, 8'h03, 8'h01, 8'h20, 8'h09,
                                           8'h09, 8'h01, 8'h03, 8'h20, 8'h21};
    // implemented code bits per register, the rest read as zero
    localparam level_bank_t level_mask = {8'h07, 8'h07, 8'h07, 8'h3f, 8'h0f,
                                          8'h0f, 8'h0f, 8'h07, 8'h3f, 8'h3f};

    typedef enum logic [5:0] {
        st_idle = 6'h01,
        st_dev = 6'h02,
        st_ptr = 6'h04,
        st_wdata = 6'h08,
        st_rdata = 6'h10,
        st_store = 6'h20
    } phase_e;

    // live level codes, laid out to match level_bank_t
    typedef struct packed {
        logic [7:0] seq_delay_third;
        logic [7:0] seq_delay_second;
        logic [7:0] seq_delay_first;
        logic [7:0] gate_off;
        logic [7:0] gate_on_hot;
        logic [7:0] gate_on_cold;
        logic [7:0] core_rail;
        logic [7:0] io_rail;
        logic [7:0] half_rail;
        logic [7:0] boost_rail;
    } rail_levels_s;

    // pins and link sample brought into the system clock domain
    typedef struct packed {
        logic scl;
        logic sda;
        logic sel;
        logic temp;
        logic link_bit;
    } pins_s;
endpackage
`default_nettype wire

/* File: verilog/bit_sync.sv */
// two-flop synchroniser for a group of slow levels
// assumes each input is stable for several destination clocks
`default_nettype none
module bit_sync
    import supply_pkg::*;
#(
    parameter int width = 1,
    parameter logic [width-1:0] rst_val = '0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [width-1:0] async_i,
    output logic [width-1:0] sync_o
);
    typedef struct packed {
        logic [width-1:0] meta;
        logic [width-1:0] stable;
    } sync_s;

    sync_s s_ff;
    sync_s nxt_s;

    // first flop only feeds the second
    always_comb
    begin
        nxt_s = s_ff;
        nxt_s.meta = async_i;
        nxt_s.stable = s_ff.meta;
    end

    // reset to the idle level of each line, so no false edge follows reset
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            s_ff <= {rst_val, rst_val};
        else
            s_ff <= nxt_s;
    end

    assign sync_o = s_ff.stable;
endmodule
`default_nettype wire

/* File: verilog/scl_sampler.sv */
// data line sampler clocked by the bus clock itself
// assumes the master holds data steady around each rising bus clock
`default_nettype none
module scl_sampler
    import supply_pkg::*;
(
    input wire logic scl_i,
    input wire logic sda_i,
    output logic bit_o
);
    typedef struct packed {
        logic sample;
    } link_s;

    link_s s_ff;
    link_s nxt_s;

    // data bit caught exactly at the rising bus clock
    always_comb
    begin
        nxt_s = s_ff;
        nxt_s.sample = sda_i;
    end

    // no reset: the value is read only after an edge has written it
    always_ff @(posedge scl_i)
    begin
        s_ff <= nxt_s;
    end

    assign bit_o = s_ff.sample;
endmodule
`default_nettype wire

/* File: verilog/panel_supply_i2c_regs.sv */
// serial slave interface and register bank of a multi-rail panel supply
// assumes an external bus master, open-drain data resolved outside
// How it works
// - device is only a slave; master starts transfers and drives the clock
// - every byte moves most significant bit first
// - data changes only while clock low; high-clock edges mean start or stop
// - data pin stays undriven after power-up until ack or read data
// - watch both lines for start; ignore bus until a start arrives
// - transmitter releases after eight bits; receiver pulls low on ninth
// - slave address is 010000 plus the select pin bit
// - direction bit zero writes, one reads
// - write is address, register pointer, one data byte, each acknowledged
// - after a level data byte return straight to idle standby
// - 80h to control register at FFh copies levels into stored bank
// - store runs 25 ms internally, then back to standby
// - during store ignore both lines and keep data pin released; the store byte's ack stays driven until the clock next falls
// - read: write 00 to control, set pointer, restart and read one byte
// - control value 01 makes reads return the stored copy
// - pointers 00h-09h map boost, half, io, core, gate-on, gate-off, delays
// - power-up values 21,20,03,01,09,09,20,01,03,03 and control 00
// - boost, half, gate-off 6 bits; core, gate-on 4; io 3 bits
// - delay code times 10 ms, codes zero to seven
// - level codes map linearly from their base voltage
// - cold gate-on while temperature above threshold, hot when below
// - three delays space the rail start-up stages
`default_nettype none
module panel_supply_i2c_regs
    import supply_pkg::*;
#(
    parameter int unsigned store_cycles_p = store_cycles
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic address_select_pin_i,
    input wire logic temperature_sense_input_i,
    output rail_levels_s levels_o,
    output logic [7:0] gate_on_active_o,
    output logic store_busy_o,
    output logic read_source_nv_o
);
    localparam int timer_w = $clog2(store_cycles_p + 1);

    typedef struct packed {
        phase_e phase;
        logic [3:0] cnt;
        logic [7:0] rx;
        logic [7:0] tx;
        logic ack;
        logic oe;
        logic [7:0] ptr;
        logic [7:0] ctrl;
        logic store_pend;
        logic [timer_w-1:0] timer;
        level_bank_t vol;
        level_bank_t nv;
        logic [7:0] gate_on;
        logic scl_q;
        logic sda_q;
        logic rise_q;
    } core_s;

    core_s s_ff;
    core_s nxt_s;
    pins_s syn;
    logic link_bit;

    // pointer may address a level register or the control register
    function automatic logic ptr_valid(input logic [7:0] p);
        ptr_valid = (p <= ptr_last) || (p == ptr_ctrl);
    endfunction

    // byte returned by a read at the current pointer
    function automatic logic [7:0] read_byte(input core_s c);
        if (c.ptr == ptr_ctrl)
            read_byte = c.ctrl;
        else if (c.ctrl == ctrl_read_nv)
            read_byte = c.nv[c.ptr[3:0]];
        else
            read_byte = c.vol[c.ptr[3:0]];
    endfunction

    // data line sampled on the bus clock's own edge
    scl_sampler u_sampler (
        .scl_i(scl_i),
        .sda_i(sda_i),
        .bit_o(link_bit)
    );

    // pins and link bit enter the system clock through two flops
    bit_sync #(
        .width($bits(pins_s)),
        .rst_val(5'h19) // scl, sda and link bit idle high, sel and temp low
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i({scl_i, sda_i, address_select_pin_i, temperature_sense_input_i, link_bit}),
        .sync_o(syn)
    );

    // bus protocol, register bank and store cycle
    always_comb
    begin
        logic rise;
        logic fall;
        logic start_ev;
        logic stop_ev;
        logic [7:0] byte_v;
        rise = s_ff.rise_q;
        fall = s_ff.scl_q & ~syn.scl;
        // start and stop seen on the synchronised lines
        start_ev = s_ff.scl_q & syn.scl & s_ff.sda_q & ~syn.sda;
        stop_ev = s_ff.scl_q & syn.scl & ~s_ff.sda_q & syn.sda;
        byte_v = {s_ff.rx[6:0], syn.link_bit};
        nxt_s = s_ff;
        nxt_s.scl_q = syn.scl;
        nxt_s.sda_q = syn.sda;
        // one cycle later the synchronised link bit is settled
        nxt_s.rise_q = ~s_ff.scl_q & syn.scl;
        // hysteresis lives in the external comparator
        nxt_s.gate_on = syn.temp ? s_ff.vol[idx_gate_on_cold]
                                 : s_ff.vol[idx_gate_on_hot];
        if (s_ff.phase == st_store)
        begin
            // bus ignored; only the pending ack is let go on the next low clock
            if (fall)
                nxt_s.oe = 1'b0;
            if (s_ff.timer == '0)
            begin
                nxt_s.phase = st_idle;
                nxt_s.nv = s_ff.vol;
                nxt_s.cnt = '0;
                nxt_s.ack = 1'b0;
            end
            else
                nxt_s.timer = s_ff.timer - timer_w'(1);
        end
        else if (start_ev)
        begin
            nxt_s.phase = st_dev;
            nxt_s.cnt = '0;
            nxt_s.ack = 1'b0;
            nxt_s.oe = 1'b0;
        end
        else if (stop_ev)
        begin
            nxt_s.phase = st_idle;
            nxt_s.cnt = '0;
            nxt_s.ack = 1'b0;
            nxt_s.oe = 1'b0;
        end
        else
        begin
            // pin drive changes only after the clock has gone low
            if (fall)
            begin
                if (s_ff.cnt == bit_ack)
                    nxt_s.oe = s_ff.ack;
                else if (s_ff.phase == st_rdata)
                    nxt_s.oe = ~s_ff.tx[3'(bit_last) - s_ff.cnt[2:0]];
                else
                    nxt_s.oe = 1'b0;
            end
            // counter and shift move one clock after the rising bus clock
            if (rise)
            begin
                if (s_ff.cnt == bit_ack)
                begin
                    // ninth clock closes the byte slot
                    nxt_s.cnt = '0;
                    nxt_s.ack = 1'b0;
                    if (s_ff.phase == st_rdata && !s_ff.ack)
                        nxt_s.phase = st_idle;
                    if (s_ff.store_pend)
                    begin
                        nxt_s.phase = st_store;
                        nxt_s.timer = timer_w'(store_cycles_p);
                        nxt_s.store_pend = 1'b0;
                    end
                end
                else if (s_ff.phase != st_idle)
                begin
                    nxt_s.cnt = s_ff.cnt + 4'h1;
                    nxt_s.rx = byte_v;
                    if (s_ff.cnt == bit_last)
                    begin
                        nxt_s.ack = 1'b0;
                        unique case (s_ff.phase)
                            st_dev:
                            begin
                                if (byte_v[7:1] == {dev_addr_hi, syn.sel})
                                begin
                                    nxt_s.ack = 1'b1;
                                    nxt_s.phase = byte_v[0] ? st_rdata : st_ptr;
                                    nxt_s.tx = read_byte(s_ff);
                                end
                                else
                                    nxt_s.phase = st_idle;
                            end
                            st_ptr:
                            begin
                                if (ptr_valid(byte_v))
                                begin
                                    nxt_s.ack = 1'b1;
                                    nxt_s.ptr = byte_v;
                                    nxt_s.phase = st_wdata;
                                end
                                else
                                    nxt_s.phase = st_idle;
                            end
                            st_wdata:
                            begin
                                nxt_s.phase = st_idle;
                                if (s_ff.ptr == ptr_ctrl)
                                begin
                                    if (byte_v == ctrl_read_vol || byte_v == ctrl_read_nv
                                        || byte_v == ctrl_store)
                                    begin
                                        nxt_s.ack = 1'b1;
                                        nxt_s.ctrl = byte_v;
                                        nxt_s.store_pend = (byte_v == ctrl_store);
                                    end
                                end
                                else
                                begin
                                    nxt_s.ack = 1'b1;
                                    nxt_s.vol[s_ff.ptr[3:0]] =
                                        byte_v & level_mask[s_ff.ptr[3:0]];
                                end
                            end
                            st_rdata:
                                nxt_s.ack = 1'b0;
                            default:
                                nxt_s.phase = st_idle;
                        endcase
                    end
                end
            end
        end
    end

    // state register; power-up contents and released pin
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            s_ff <= '{phase: st_idle, ctrl: ctrl_reset, vol: level_reset,
                      nv: level_reset, gate_on: level_reset[idx_gate_on_cold],
                      scl_q: 1'b1, sda_q: 1'b1, default: '0};
        else
            s_ff <= nxt_s;
    end

    // open drain: only ever pull low, never drive the clock line
    assign sda_o = 1'b0;
    assign sda_oe_o = s_ff.oe;
    // codes leave as plain linear codes for the analog and sequencer
    assign levels_o = rail_levels_s'(s_ff.vol);
    assign gate_on_active_o = s_ff.gate_on;
    assign store_busy_o = (s_ff.phase == st_store);
    assign read_source_nv_o = (s_ff.ctrl == ctrl_read_nv);

    // checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    int unsigned busy_len;

    // length of the current store cycle in clocks
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !store_busy_o)
            busy_len <= 0;
        else
            busy_len <= busy_len + 1;
    end

    chk_drive_clock_low: assert property (
        $changed(sda_oe_o) |-> !s_ff.scl_q)
        else $error("data drive changed while bus clock high");

    chk_store_released: assert property (
        store_busy_o && !s_ff.scl_q |-> !sda_oe_o)
        else $error("data pin driven during store");

    chk_store_length: assert property (
        $fell(store_busy_o) |-> busy_len == store_cycles_p + 1)
        else $error("store cycle length wrong");

    chk_store_copies: assert property (
        $fell(store_busy_o) |-> s_ff.nv == s_ff.vol)
        else $error("stored bank differs after store");

    chk_idle_quiet: assert property (
        s_ff.phase == st_idle && !s_ff.ack && !sda_oe_o |=> !sda_oe_o)
        else $error("idle device drove the data pin");

    chk_addr_match: assert property (
        $changed(s_ff.phase) && s_ff.phase == st_ptr
            |-> s_ff.rx == {dev_addr_hi, $past(syn.sel), 1'b0})
        else $error("write accepted for another address");

    chk_ctrl_values: assert property (
        s_ff.ctrl == ctrl_read_vol || s_ff.ctrl == ctrl_read_nv || s_ff.ctrl == ctrl_store)
        else $error("control register holds an unsupported value");

    chk_reserved_zero: assert property (
        (s_ff.vol & ~level_mask) == '0)
        else $error("reserved level bits set");

    chk_level_to_idle: assert property (
        $changed(s_ff.vol) |-> s_ff.phase == st_idle ##1 s_ff.phase != st_store)
        else $error("level write did not return to idle");

    chk_gate_select: assert property (
        syn.temp |=> gate_on_active_o == $past(s_ff.vol[idx_gate_on_cold]))
        else $error("cold gate-on level not applied");

    chk_gate_hot: assert property (
        !syn.temp |=> gate_on_active_o == $past(s_ff.vol[idx_gate_on_hot]))
        else $error("hot gate-on level not applied");

    chk_read_release: assert property (
        s_ff.phase == st_rdata && s_ff.cnt == bit_ack && !s_ff.ack && !s_ff.scl_q
            |-> !sda_oe_o)
        else $error("data pin held after the eighth read bit");

    chk_drive_slot: assert property (
        $rose(sda_oe_o) |-> s_ff.cnt == bit_ack || s_ff.phase == st_rdata)
        else $error("data pin driven outside an ack or read slot");

    cov_store: cover property ($fell(store_busy_o));
    cov_read: cover property ($fell(s_ff.phase == st_rdata));
    cov_write: cover property ($changed(s_ff.vol));
    cov_nv_read: cover property (read_source_nv_o && s_ff.phase == st_rdata);
    cov_refused: cover property ($fell(s_ff.phase == st_dev) && s_ff.phase == st_idle);
endmodule
`default_nettype wire

/* File: sim/master.sv */
// behavioural bus master driving the link clock and data line
// assumes a pull-up on data; sda_i is the resolved wire level
`default_nettype none
module master (
    output logic scl_o,
    output logic sda_o,
    input wire logic sda_i
);
    timeunit 1ns;
    timeprecision 100ps;
    // bus idle, clock stands still high between frames
    initial
    begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // start or repeated start, data falls while clock high
    task automatic start();
        #11 sda_o = 1'b1; // odd delay keeps link edges off the system clock edges
        #32 scl_o = 1'b1;
        #32 sda_o = 1'b0;
        #32 scl_o = 1'b0;
    endtask
    // stop, data rises while clock high
    task automatic stop();
        #8 sda_o = 1'b0;
        #24 scl_o = 1'b1;
        #32 sda_o = 1'b1;
    endtask
    // one 64 ns slot, data set in the low phase, sampled mid high
    task automatic slot(input logic d, output logic q);
        #8 sda_o = d;
        #24 scl_o = 1'b1;
        #16 q = sda_i;
        #16 scl_o = 1'b0;
    endtask
    // byte out msb first, ninth slot released for the ack
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic q;
        for (int i = 7; i >= 0; i--)
            slot(b[i], q);
        slot(1'b1, q);
        ack = ~q;
    endtask
    // byte in msb first, then no ack on the ninth slot
    task automatic get_byte(output logic [7:0] b);
        logic q;
        for (int i = 0; i < 8; i++)
        begin
            slot(1'b1, q);
            b = {b[6:0], q};
        end
        slot(1'b1, q);
    endtask
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
// self-checking bench of the panel supply serial register block
// assumes the master model drives the link, data wire pulled up
`default_nettype none
module testbench
    import supply_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int store_n = 200;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic sel = 1'b0;
    logic temp = 1'b0;
    logic dut_sda, dut_oe, busy, src_nv;
    logic [7:0] gate_on;
    rail_levels_s levels;
    wire scl, host_sda;
    wire sda_line = host_sda & ~(dut_oe & ~dut_sda);
    int failures = 0;
    int comparisons = 0;
    int busy_n = 0;
    int dft[10] = '{8'h21, 8'h20, 8'h03, 8'h01, 8'h09, 8'h09, 8'h20, 8'h01, 8'h03,
        8'h03};
    int msk[10] = '{8'h3f, 8'h3f, 8'h07, 8'h0f, 8'h0f, 8'h0f, 8'h3f, 8'h07, 8'h07,
        8'h07};
    int vol[10];
    int nv[10];
    int ctrl = 0;
    logic [31:0] seed = 32'hce1ccc91;

    // device with a short store cycle, master on the far side
    panel_supply_i2c_regs #(.store_cycles_p(store_n)) panel_supply_i2c_regs_inst (
        .clk_i(clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda_line), .sda_o(dut_sda),
        .sda_oe_o(dut_oe), .address_select_pin_i(sel), .temperature_sense_input_i(temp),
        .levels_o(levels), .gate_on_active_o(gate_on), .store_busy_o(busy),
        .read_source_nv_o(src_nv)
    );
    master master_inst (.scl_o(scl), .sda_o(host_sda), .sda_i(sda_line));

    // system clock
    initial
    begin
        forever #4 clk_i = ~clk_i;
    end

    task automatic report_and_stop();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [95:0] got, input logic [95:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction

    // model bank packed as the level outputs
    function automatic logic [79:0] exp_lv();
        logic [79:0] v;
        for (int i = 0; i < 10; i++)
            v[i*8 +: 8] = vol[i][7:0];
        return v;
    endfunction

    task automatic gap();
        repeat (10) @(posedge clk_i);
    endtask

    // write frame, acks compared, model updated when accepted
    task automatic wr(input logic [7:0] p, input logic [7:0] d, input logic [2:0] e,
        input logic bad = 1'b0);
        logic [2:0] a;
        master_inst.start();
        master_inst.put_byte({6'h10, sel ^ bad, 1'b0}, a[2]);
        master_inst.put_byte(p, a[1]);
        master_inst.put_byte(d, a[0]);
        master_inst.stop();
        chk(a, e);
        if (e == 3'b111)
        begin
            if (p == 8'hff && d == 8'h80)
                nv = vol;
            if (p == 8'hff)
                ctrl = d;
            else
                vol[p] = d & msk[p];
        end
        gap();
    endtask

    // pointer set, repeated start, one byte read
    task automatic rd(input logic [7:0] p, output logic [7:0] d);
        logic [2:0] a;
        master_inst.start();
        master_inst.put_byte({6'h10, sel, 1'b0}, a[2]);
        master_inst.put_byte(p, a[1]);
        master_inst.start();
        master_inst.put_byte({6'h10, sel, 1'b1}, a[0]);
        master_inst.get_byte(d);
        master_inst.stop();
        chk(a, 3'b111);
        gap();
    endtask

    // store length counted at the pins
    always @(posedge clk_i)
    begin
        if (busy === 1'b1)
            busy_n <= busy_n + 1;
        else if (busy_n != 0)
        begin
            chk(busy_n, store_n + 1);
            busy_n <= 0;
        end
    end

    // watchdog against a hung link
    initial
    begin
        #400000;
        failures++;
        report_and_stop();
    end

    // main sequence
    initial
    begin
        logic [7:0] r;
        vol = dft;
        nv = dft;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        gap();
        chk({dut_oe, busy, src_nv, gate_on, levels}, {3'b000, 8'h09, exp_lv()});
        // both select values, every level pointer read then written at random
        for (int s = 0; s < 2; s++)
        begin
            @(posedge clk_i);
            sel <= s[0];
            gap();
            for (int p = 0; p < 10; p++)
            begin
                rd(p[7:0], r);
                chk(r, vol[p]);
                seed = xs(seed);
                wr(p[7:0], seed[7:0], 3'b111);
                chk(levels, exp_lv());
            end
        end
        // wrong address, bad pointer, bad control value change nothing
        wr(8'h02, 8'h05, 3'b000, 1'b1);
        wr(8'h0a, 8'h05, 3'b100);
        wr(8'hff, 8'h02, 3'b110);
        rd(8'hff, r);
        chk({src_nv, r, levels}, {1'b0, ctrl[7:0], exp_lv()});
        // temperature input picks the gate-on code, both directions
        for (int t = 1; t >= 0; t--)
        begin
            @(posedge clk_i);
            temp <= t[0];
            gap();
            chk(gate_on, vol[5 - t]);
        end
        // store, then a frame sent while it runs goes unanswered
        wr(8'hff, 8'h80, 3'b111);
        wr(8'h03, 8'h01, 3'b000);
        for (int i = 0; i < 400 && busy !== 1'b0; i++)
            @(posedge clk_i);
        chk({busy, levels}, {1'b0, exp_lv()});
        // stored copy and volatile bank told apart by the control value
        for (int p = 0; p < 10; p++)
        begin
            seed = xs(seed);
            wr(p[7:0], seed[7:0], 3'b111);
            wr(8'hff, 8'h01, 3'b111);
            rd(p[7:0], r);
            chk({src_nv, r}, {1'b1, nv[p][7:0]});
            wr(8'hff, 8'h00, 3'b111);
            rd(p[7:0], r);
            chk({src_nv, r}, {1'b0, vol[p][7:0]});
        end
        // second reset brings the power-up codes back
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        gap();
        vol = dft;
        chk({dut_oe, busy, src_nv, levels}, {3'b000, exp_lv()});
        report_and_stop();
    end
endmodule
`default_nettype wire
